// ===== hdl/csw_device.sv
module csw_device (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Link to the host.
  csw_if.device link,
  // Device state.
  input wire logic stop_mode_i,
  input wire logic normal_mode_i,
  input wire logic wake_mode_enabled_i,
  input wire logic wake_event_i,
  input wire logic can_timeout_event_i,
  // Received frame.
  input wire logic rx_valid_i,
  input wire logic [28:0] rx_ident_i,
  input wire logic rx_rtr_i,
  input wire logic rx_ide_i,
  // Configuration, status, trim reference and wake match outputs.
  output logic selective_wake_enable_o,
  output logic osc_trim_active_o,
  output logic trim_ref_o,
  output logic low_power_receiver_option_o,
  output logic [7:0] quanta_per_bit_o,
  output logic [5:0] sample_point_fraction_o,
  output logic bus_timeout_flag_o,
  output logic wake_frame_match_o
);
  logic [2:0] sclk_s;
  logic [1:0] cs_s;
  logic [1:0] mosi_s;
  logic [1:0] txd_s;
  logic rise;
  logic fall;
  logic [4:0] bit_cnt;
  logic [6:0] rx_sh;
  logic [6:0] addr_q;
  logic wr_flag;
  logic load_q;
  logic [7:0] tx_sh;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rdata;
  logic cfg_write;
  logic [7:0] ctrl;
  logic [7:0] quanta;
  logic [5:0] sample_pt;
  logic [7:0] id_top;
  logic [7:0] id_umid;
  logic [7:0] id_lmid;
  logic [6:0] id_low;
  logic [7:0] mask_top;
  logic [7:0] mask_umid;
  logic [7:0] mask_lmid;
  logic [4:0] mask_low;
  logic lp_option;
  logic timeout_flag;
  logic unlocked;
  logic [28:0] cfg_ident;
  logic [28:0] cfg_mask;
  logic [28:0] eff_mask;
  logic match;

  // Pin synchronisers; edges are taken from the second stage onward.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sclk_s <= 3'h0;
      cs_s <= 2'h3;
      mosi_s <= 2'h0;
      txd_s <= 2'h3;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      cs_s <= {cs_s[0], link.cs_n};
      mosi_s <= {mosi_s[0], link.mosi};
      txd_s <= {txd_s[0], link.can_transmit_data_pin};
    end
  end

  assign rise = sclk_s[1] & ~sclk_s[2] & ~cs_s[1];
  assign fall = ~sclk_s[1] & sclk_s[2] & ~cs_s[1];

  // Receive side: address byte then data byte, MSB first.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || cs_s[1]) begin
      bit_cnt <= 5'h00;
      rx_sh <= 7'h00;
      addr_q <= 7'h00;
      wr_flag <= 1'b0;
      load_q <= 1'b0;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      load_q <= rise && bit_cnt == 5'h07;
      wr_en <= rise && bit_cnt == 5'h0f && wr_flag;
      if (rise) begin
        bit_cnt <= bit_cnt + 5'h01;
        rx_sh <= {rx_sh[5:0], mosi_s[1]};
        if (bit_cnt == 5'h07) begin
          wr_flag <= rx_sh[6];
          addr_q <= {rx_sh[5:0], mosi_s[1]};
        end
        if (bit_cnt == 5'h0f) begin
          wr_data <= {rx_sh, mosi_s[1]};
        end
      end
    end
  end

  // Transmit side: read data goes out while the data byte comes in.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || cs_s[1]) begin
      tx_sh <= 8'h00;
    end else if (load_q) begin
      tx_sh <= rdata;
    end else if (fall && bit_cnt >= 5'h09) begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  assign link.miso = tx_sh[7];

  // Read data; reserved bits come back as zero.
  always_comb begin
    unique case (addr_q)
      csw_pkg::ADDR_CTRL: rdata = {ctrl[7:4], 3'h0, ctrl[0]};
      csw_pkg::ADDR_BIT_QUANTA: rdata = quanta;
      csw_pkg::ADDR_SAMPLE_POINT: rdata = {2'h0, sample_pt};
      csw_pkg::ADDR_IDENT_TOP: rdata = id_top;
      csw_pkg::ADDR_IDENT_UMID: rdata = id_umid;
      csw_pkg::ADDR_IDENT_LMID: rdata = id_lmid;
      csw_pkg::ADDR_IDENT_LOW: rdata = {1'b0, id_low};
      csw_pkg::ADDR_MASK_TOP: rdata = mask_top;
      csw_pkg::ADDR_MASK_UMID: rdata = mask_umid;
      csw_pkg::ADDR_MASK_LMID: rdata = mask_lmid;
      csw_pkg::ADDR_MASK_LOW: rdata = {1'b0, mask_low, 2'h0};
      csw_pkg::ADDR_LP_OPTION: rdata = {7'h00, lp_option};
      csw_pkg::ADDR_BUS_STATUS: rdata = {7'h00, timeout_flag};
      default: rdata = 8'h00;
    endcase
  end

  // Any write to a configuration register other than control.
  assign cfg_write = wr_en && addr_q >= csw_pkg::ADDR_BIT_QUANTA
                     && (addr_q <= csw_pkg::ADDR_MASK_LOW
                         || addr_q == csw_pkg::ADDR_LP_OPTION);

  // Control register.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl <= csw_pkg::RST_CTRL;
    end else begin
      if (wr_en && addr_q == csw_pkg::ADDR_CTRL) begin
        ctrl[7:4] <= wr_data[7:4];
        ctrl[0] <= wr_data[0] & ~stop_mode_i;
      end
      if (wake_event_i || cfg_write) begin
        ctrl[0] <= 1'b0;
      end
      ctrl[3:1] <= 3'h0;
    end
  end

  // Bit timing and identifier configuration.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      quanta <= csw_pkg::RST_BIT_QUANTA;
      sample_pt <= csw_pkg::RST_SAMPLE_POINT[5:0];
      id_top <= csw_pkg::RST_ZERO;
      id_umid <= csw_pkg::RST_ZERO;
      id_lmid <= csw_pkg::RST_ZERO;
      id_low <= csw_pkg::RST_ZERO[6:0];
      mask_top <= csw_pkg::RST_ZERO;
      mask_umid <= csw_pkg::RST_ZERO;
      mask_lmid <= csw_pkg::RST_ZERO;
      mask_low <= csw_pkg::RST_ZERO[4:0];
    end else if (wr_en) begin
      unique case (addr_q)
        csw_pkg::ADDR_BIT_QUANTA: quanta <= wr_data;
        csw_pkg::ADDR_SAMPLE_POINT: sample_pt <= wr_data[5:0];
        csw_pkg::ADDR_IDENT_TOP: id_top <= wr_data;
        csw_pkg::ADDR_IDENT_UMID: id_umid <= wr_data;
        csw_pkg::ADDR_IDENT_LMID: id_lmid <= wr_data;
        csw_pkg::ADDR_IDENT_LOW: id_low <= wr_data[6:0];
        csw_pkg::ADDR_MASK_TOP: mask_top <= wr_data;
        csw_pkg::ADDR_MASK_UMID: mask_umid <= wr_data;
        csw_pkg::ADDR_MASK_LMID: mask_lmid <= wr_data;
        csw_pkg::ADDR_MASK_LOW: mask_low <= wr_data[6:2];
        default: ;
      endcase
    end
  end

  assign unlocked = ctrl[csw_pkg::CTRL_KEY_HI:csw_pkg::CTRL_KEY_LO]
                    == csw_pkg::KEY_UNLOCK;

  // Low-power receiver option only accepts writes while unlocked.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      lp_option <= 1'b0;
    end else if (wr_en && addr_q == csw_pkg::ADDR_LP_OPTION && unlocked) begin
      lp_option <= wr_data[0];
    end
  end

  // Time-out flag: with wake mode enabled, the event wins over a clear written in the same cycle.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      timeout_flag <= 1'b0;
    end else if (can_timeout_event_i && wake_mode_enabled_i) begin
      timeout_flag <= 1'b1;
    end else if (wr_en && addr_q == csw_pkg::ADDR_BUS_STATUS
                 && wr_data[0]) begin
      timeout_flag <= 1'b0;
    end
  end

  // Interrupt pin, active low.
  assign link.int_n = ~(timeout_flag && ctrl[csw_pkg::CTRL_TO_IRQ_POS]
                        && wake_mode_enabled_i
                        && (normal_mode_i || stop_mode_i));

  // Wake frame comparison.
  assign cfg_ident = {id_top, id_umid, id_lmid, id_low[6:2]};
  assign cfg_mask = {mask_top, mask_umid, mask_lmid, mask_low};
  assign eff_mask = id_low[csw_pkg::IDLOW_IDE_POS] ? cfg_mask
                    : (cfg_mask & csw_pkg::STD_ID_SEL);
  assign match = rx_valid_i && ctrl[csw_pkg::CTRL_VALID_POS]
                 && ((rx_ident_i ^ cfg_ident) & eff_mask) == 29'h0
                 && rx_rtr_i == id_low[csw_pkg::IDLOW_RTR_POS]
                 && rx_ide_i == id_low[csw_pkg::IDLOW_IDE_POS];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wake_frame_match_o <= 1'b0;
      trim_ref_o <= 1'b1;
    end else begin
      wake_frame_match_o <= match;
      trim_ref_o <= txd_s[1];
    end
  end

  assign selective_wake_enable_o = ctrl[csw_pkg::CTRL_VALID_POS];
  assign osc_trim_active_o = ctrl[csw_pkg::CTRL_OSC_CALIBRATE_ENABLE_POS]
                             && unlocked;
  assign low_power_receiver_option_o = lp_option;
  assign quanta_per_bit_o = quanta;
  assign sample_point_fraction_o = sample_pt;
  assign bus_timeout_flag_o = timeout_flag;
endmodule

// ===== hdl/csw_host.sv
module csw_host (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Link to the device.
  csw_if.host link,
  // Command port.
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [6:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_rdata_o,
  // Trim reference and interrupt.
  input wire logic trim_ref_i,
  output logic irq_o
);
  typedef enum logic [1:0] {IDLE, LOW_PH, HIGH_PH, GAP} csw_hstate_t;

  csw_hstate_t state;
  logic [7:0] half_cnt;
  logic [3:0] bit_idx;
  logic [15:0] tx_sh;
  logic [7:0] rx_sh;
  logic [1:0] miso_s;
  logic [1:0] int_s;
  logic half_done;

  assign half_done = half_cnt == 8'(csw_pkg::SCK_HALF_CYC - 1);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      miso_s <= 2'h0;
      int_s <= 2'h3;
    end else begin
      miso_s <= {miso_s[0], link.miso};
      int_s <= {int_s[0], link.int_n};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= IDLE;
      half_cnt <= 8'h00;
      bit_idx <= 4'h0;
      tx_sh <= 16'h0000;
      rx_sh <= 8'h00;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 8'h00;
    end else begin
      rsp_valid_o <= 1'b0;
      half_cnt <= half_done ? 8'h00 : half_cnt + 8'h01;
      unique case (state)
        IDLE: begin
          half_cnt <= 8'h00;
          bit_idx <= 4'h0;
          if (cmd_valid_i) begin
            // The remote-request bit is never set in an identifier write.
            tx_sh <= {cmd_write_i, cmd_addr_i,
                      cmd_addr_i == csw_pkg::ADDR_IDENT_LOW
                      ? (cmd_wdata_i & 8'hfd) : cmd_wdata_i};
            state <= LOW_PH;
          end
        end
        LOW_PH: begin
          if (half_done) begin
            rx_sh <= {rx_sh[6:0], miso_s[1]};
            state <= HIGH_PH;
          end
        end
        HIGH_PH: begin
          if (half_done) begin
            tx_sh <= {tx_sh[14:0], 1'b0};
            bit_idx <= bit_idx + 4'h1;
            state <= (bit_idx == 4'hf) ? GAP : LOW_PH;
          end
        end
        GAP: begin
          if (half_done) begin
            rsp_valid_o <= 1'b1;
            rsp_rdata_o <= rx_sh;
            state <= IDLE;
          end
        end
      endcase
    end
  end

  assign cmd_ready_o = state == IDLE;
  assign link.sclk = state == HIGH_PH;
  assign link.cs_n = state == IDLE || state == GAP;
  assign link.mosi = tx_sh[15];
  assign link.can_transmit_data_pin = trim_ref_i;
  assign irq_o = ~int_s[1];
endmodule

// ===== hdl/csw_if.sv
interface csw_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic can_transmit_data_pin;
  logic int_n;

  modport device (
    input sclk,
    input cs_n,
    input mosi,
    output miso,
    input can_transmit_data_pin,
    output int_n
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input miso,
    output can_transmit_data_pin,
    input int_n
  );
endinterface

// ===== hdl/csw_pkg.sv
package csw_pkg;
  // Serial frame: bit 15 write flag, bits 14:8 address, bits 7:0 data.
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 7;
  localparam int WR_FLAG_POS = 15;
  localparam int ADDR_POS = 8;

  // Register addresses.
  localparam logic [6:0] ADDR_CTRL = 7'h20;
  localparam logic [6:0] ADDR_BIT_QUANTA = 7'h21;
  localparam logic [6:0] ADDR_SAMPLE_POINT = 7'h22;
  localparam logic [6:0] ADDR_IDENT_TOP = 7'h23;
  localparam logic [6:0] ADDR_IDENT_UMID = 7'h24;
  localparam logic [6:0] ADDR_IDENT_LMID = 7'h25;
  localparam logic [6:0] ADDR_IDENT_LOW = 7'h26;
  localparam logic [6:0] ADDR_MASK_TOP = 7'h27;
  localparam logic [6:0] ADDR_MASK_UMID = 7'h28;
  localparam logic [6:0] ADDR_MASK_LMID = 7'h29;
  localparam logic [6:0] ADDR_MASK_LOW = 7'h2a;
  localparam logic [6:0] ADDR_LP_OPTION = 7'h35;
  localparam logic [6:0] ADDR_BUS_STATUS = 7'h45;

  // Control register fields.
  localparam int CTRL_OSC_CALIBRATE_ENABLE_POS = 7;
  localparam int CTRL_KEY_HI = 6;
  localparam int CTRL_KEY_LO = 5;
  localparam int CTRL_TO_IRQ_POS = 4;
  localparam int CTRL_VALID_POS = 0;
  localparam logic [1:0] KEY_UNLOCK = 2'h3;

  // Identifier low register fields and standard identifier placement.
  localparam int IDLOW_ID_HI = 6;
  localparam int IDLOW_ID_LO = 2;
  localparam int IDLOW_RTR_POS = 1;
  localparam int IDLOW_IDE_POS = 0;
  localparam logic [28:0] STD_ID_SEL = 29'h1ffc_0000;
  localparam int SP_BITS = 6;

  // Reset values.
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_BIT_QUANTA = 8'ha0;
  localparam logic [7:0] RST_SAMPLE_POINT = 8'h33;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Serial clock timing of the host end.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_HALF_NS = 80;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
endpackage

// ===== tb/csw_properties.sv
module csw_properties (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Link signals.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic can_transmit_data_pin,
  input wire logic int_n,
  // Device ports.
  input wire logic stop_mode_i,
  input wire logic normal_mode_i,
  input wire logic wake_mode_enabled_i,
  input wire logic wake_event_i,
  input wire logic can_timeout_event_i,
  input wire logic rx_valid_i,
  input wire logic selective_wake_enable_o,
  input wire logic trim_ref_o,
  input wire logic bus_timeout_flag_o,
  input wire logic wake_frame_match_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic [4:0] n_rise;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  always_ff @(posedge clk_sys_i) begin
    sclk_q <= sclk;
  end

  // Serial clock rises seen within the current frame.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || cs_n) begin
      n_rise <= 5'h00;
    end else if (sclk && !sclk_q) begin
      n_rise <= n_rise + 5'h01;
    end
  end

  property p_sclk_half;
    $rose(sclk) |-> sclk [*8] ##1 !sclk;
  endproperty
  property p_cs_gap;
    $rose(cs_n) |-> cs_n [*8];
  endproperty
  property p_frame_len;
    $fell(cs_n) |-> ##255 !cs_n ##[1:8] cs_n;
  endproperty
  property p_frame_bits;
    $rose(cs_n) |-> n_rise == 5'h10;
  endproperty
  property p_mosi_stable;
    sclk |-> $stable(mosi);
  endproperty
  property p_int_cause;
    !int_n |-> bus_timeout_flag_o && wake_mode_enabled_i
      && (normal_mode_i || stop_mode_i);
  endproperty
  property p_flag_cause;
    $rose(bus_timeout_flag_o) |->
      $past(can_timeout_event_i) && $past(wake_mode_enabled_i);
  endproperty
  property p_match_cause;
    wake_frame_match_o |-> $past(rx_valid_i) && $past(selective_wake_enable_o);
  endproperty
  property p_wake_clears;
    wake_event_i |=> !selective_wake_enable_o;
  endproperty
  property p_trim_follow;
    $rose(can_transmit_data_pin) |-> ##[1:5] trim_ref_o;
  endproperty

  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock half period wrong");
  a_cs_gap: assert property (p_cs_gap)
    else $error("frame gap too short");
  a_frame_len: assert property (p_frame_len)
    else $error("frame length wrong");
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame bit count wrong");
  a_mosi_stable: assert property (p_mosi_stable)
    else $error("host data moved while clock high");
  a_int_cause: assert property (p_int_cause)
    else $error("interrupt without time-out cause");
  a_flag_cause: assert property (p_flag_cause)
    else $error("time-out flag set without cause");
  a_match_cause: assert property (p_match_cause)
    else $error("match without valid frame and config");
  a_wake_clears: assert property (p_wake_clears)
    else $error("wake did not clear config valid");
  a_trim_follow: assert property (p_trim_follow)
    else $error("trim reference did not follow pin");

  c_match: cover property (wake_frame_match_o);
  c_int: cover property (!int_n);
  c_frame: cover property ($fell(cs_n));
endmodule

// ===== tb/csw_tb_top.sv
module csw_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic stop_mode_i = 1'b0, normal_mode_i = 1'b1, wake_mode_enabled_i = 1'b0;
  logic wake_event_i = 1'b0, can_timeout_event_i = 1'b0;
  logic rx_valid_i = 1'b0, rx_rtr_i = 1'b0, rx_ide_i = 1'b0;
  logic [28:0] rx_ident_i = 29'h0000_0000;
  logic cmd_valid_i = 1'b0, cmd_write_i = 1'b0, trim_ref_i = 1'b1;
  logic [6:0] cmd_addr_i = 7'h00;
  logic [7:0] cmd_wdata_i = 8'h00;
  logic cmd_ready_o, rsp_valid_o, irq_o, selective_wake_enable_o;
  logic osc_trim_active_o, trim_ref_o, low_power_receiver_option_o;
  logic bus_timeout_flag_o, wake_frame_match_o;
  logic [7:0] rsp_rdata_o, quanta_per_bit_o;
  logic [5:0] sample_point_fraction_o;
  logic [28:0] wid = 29'h1a5c_3e97;
  int miscompares = 0;
  int checks_done = 0;

  csw_if link();

  csw_device csw_device_i (.clk_sys_i, .rst_n_i, .link, .stop_mode_i,
    .normal_mode_i, .wake_mode_enabled_i, .wake_event_i,
    .can_timeout_event_i, .rx_valid_i, .rx_ident_i, .rx_rtr_i, .rx_ide_i,
    .selective_wake_enable_o, .osc_trim_active_o, .trim_ref_o,
    .low_power_receiver_option_o, .quanta_per_bit_o,
    .sample_point_fraction_o, .bus_timeout_flag_o, .wake_frame_match_o);

  csw_host csw_host_i (.clk_sys_i, .rst_n_i, .link, .cmd_valid_i,
    .cmd_write_i, .cmd_addr_i, .cmd_wdata_i, .cmd_ready_o, .rsp_valid_o,
    .rsp_rdata_o, .trim_ref_i, .irq_o);

  csw_properties csw_properties_i (.clk_sys_i, .rst_n_i, .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .int_n(link.int_n),
    .can_transmit_data_pin(link.can_transmit_data_pin), .stop_mode_i,
    .normal_mode_i, .wake_mode_enabled_i, .wake_event_i,
    .can_timeout_event_i, .rx_valid_i, .selective_wake_enable_o,
    .trim_ref_o, .bus_timeout_flag_o, .wake_frame_match_o);

  always #5 clk_sys_i = ~clk_sys_i;

  task automatic test_done;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  // One command through the host end; the next may follow at once.
  task automatic xfer(input logic wr, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b1;
    cmd_write_i <= wr;
    cmd_addr_i <= a;
    cmd_wdata_i <= d;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    @(negedge clk_sys_i);
    chk_bit(cmd_ready_o, 1'b0);
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (rsp_valid_o !== 1'b1 && n < 400);
    if (n >= 400) begin
      miscompares++;
      $display("[ERR] %0t no response", $time);
    end
    q = rsp_rdata_o;
    chk_bit(cmd_ready_o, 1'b1);
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk_byte(q, exp);
  endtask

  task automatic frame(input logic [28:0] id, input logic rtr,
                       input logic ide, input logic exp);
    @(posedge clk_sys_i);
    rx_valid_i <= 1'b1;
    rx_ident_i <= id;
    rx_rtr_i <= rtr;
    rx_ide_i <= ide;
    @(posedge clk_sys_i);
    rx_valid_i <= 1'b0;
    @(negedge clk_sys_i);
    chk_bit(wake_frame_match_o, exp);
  endtask

  task automatic timeout_pulse(input logic exp);
    @(posedge clk_sys_i);
    can_timeout_event_i <= 1'b1;
    @(posedge clk_sys_i);
    can_timeout_event_i <= 1'b0;
    @(negedge clk_sys_i);
    chk_bit(bus_timeout_flag_o, exp);
  endtask

  task automatic t_reset_values;
    logic [7:0] exp [8] = '{8'h00, 8'ha0, 8'h33, 8'h00, 8'h00, 8'h00,
                            8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd(7'(csw_pkg::ADDR_CTRL + i), exp[i]);
    end
    rd(7'h10, 8'h00);
  endtask

  task automatic t_fields;
    wr(csw_pkg::ADDR_CTRL, 8'hff);
    rd(csw_pkg::ADDR_CTRL, 8'hf1);
    chk_bit(selective_wake_enable_o, 1'b1);
    wr(csw_pkg::ADDR_SAMPLE_POINT, 8'hff);
    rd(csw_pkg::ADDR_SAMPLE_POINT, 8'h3f);
    chk_byte({2'h0, sample_point_fraction_o}, 8'h3f);
    chk_bit(selective_wake_enable_o, 1'b0);
    wr(csw_pkg::ADDR_IDENT_LOW, 8'hff);
    rd(csw_pkg::ADDR_IDENT_LOW, 8'h7d);
    wr(csw_pkg::ADDR_BIT_QUANTA, 8'h5a);
    chk_byte(quanta_per_bit_o, 8'h5a);
  endtask

  task automatic t_key;
    for (int k = 0; k < 4; k++) begin
      wr(csw_pkg::ADDR_CTRL, {1'b1, 2'(k), 5'h00});
      chk_bit(osc_trim_active_o, k == 3);
      wr(csw_pkg::ADDR_LP_OPTION, 8'h01);
      chk_bit(low_power_receiver_option_o, k == 3);
    end
    rd(csw_pkg::ADDR_LP_OPTION, 8'h01);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_sys_i);
      trim_ref_i <= 1'(v);
      repeat (8) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk_bit(trim_ref_o, 1'(v));
    end
    wr(csw_pkg::ADDR_CTRL, 8'h60);
    chk_bit(osc_trim_active_o, 1'b0);
  endtask

  task automatic t_timeout;
    wr(csw_pkg::ADDR_CTRL, 8'h10);
    timeout_pulse(1'b0);
    @(posedge clk_sys_i);
    wake_mode_enabled_i <= 1'b1;
    timeout_pulse(1'b1);
    rd(csw_pkg::ADDR_BUS_STATUS, 8'h01);
    repeat (4) @(negedge clk_sys_i);
    chk_bit(link.int_n, 1'b0);
    chk_bit(irq_o, 1'b1);
    wr(csw_pkg::ADDR_CTRL, 8'h00);
    chk_bit(link.int_n, 1'b1);
    chk_bit(irq_o, 1'b0);
    wr(csw_pkg::ADDR_BUS_STATUS, 8'h01);
    chk_bit(bus_timeout_flag_o, 1'b0);
  endtask

  task automatic t_match;
    wr(csw_pkg::ADDR_IDENT_TOP, wid[28:21]);
    wr(csw_pkg::ADDR_IDENT_UMID, wid[20:13]);
    wr(csw_pkg::ADDR_IDENT_LMID, wid[12:5]);
    wr(csw_pkg::ADDR_IDENT_LOW, {1'b0, wid[4:0], 2'h1});
    wr(csw_pkg::ADDR_MASK_TOP, 8'hff);
    wr(csw_pkg::ADDR_MASK_UMID, 8'hff);
    wr(csw_pkg::ADDR_MASK_LMID, 8'h00);
    wr(csw_pkg::ADDR_MASK_LOW, 8'h7c);
    rd(csw_pkg::ADDR_MASK_LOW, 8'h7c);
    wr(csw_pkg::ADDR_CTRL, 8'h01);
    chk_bit(selective_wake_enable_o, 1'b1);
    frame(wid, 1'b0, 1'b1, 1'b1);
    frame(wid ^ 29'h0000_0080, 1'b0, 1'b1, 1'b1);
    frame(wid ^ 29'h0200_0000, 1'b0, 1'b1, 1'b0);
    frame(wid ^ 29'h0000_0008, 1'b0, 1'b1, 1'b0);
    frame(wid, 1'b1, 1'b1, 1'b0);
    frame(wid, 1'b0, 1'b0, 1'b0);
    wr(csw_pkg::ADDR_IDENT_LOW, {1'b0, wid[4:0], 2'h0});
    wr(csw_pkg::ADDR_CTRL, 8'h01);
    frame(wid ^ 29'h0003_ffff, 1'b0, 1'b0, 1'b1);
    frame(wid ^ 29'h0004_0000, 1'b0, 1'b0, 1'b0);
    @(posedge clk_sys_i);
    wake_event_i <= 1'b1;
    @(posedge clk_sys_i);
    wake_event_i <= 1'b0;
    @(negedge clk_sys_i);
    chk_bit(selective_wake_enable_o, 1'b0);
    frame(wid, 1'b0, 1'b0, 1'b0);
    wr(csw_pkg::ADDR_CTRL, 8'h01);
    stop_mode_i <= 1'b1;
    wr(csw_pkg::ADDR_CTRL, 8'h01);
    chk_bit(selective_wake_enable_o, 1'b0);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset_values;
    t_fields;
    t_key;
    t_timeout;
    t_match;
    test_done;
  end

  initial begin
    repeat (40000) @(posedge clk_sys_i);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done;
  end
endmodule
